// ### verilog/smd_pkg.sv
// Constants, types and helpers shared by the serial port mask and channel register bank.
// How it works
// (R1) Enable, disable and mask registers share one six-bit source layout, rest unused.
// (R2) Writing one to the enable register sets that mask bit; zero does nothing.
// (R3) Writing one to the disable register clears that mask bit; zero does nothing.
// (R4) Reading the mask register shows one for each enabled source.
// (R5) Software loads the receive pointer with the receive buffer address first.
// (R6) Software loads 16-bit buffer sizes into the low half of both counters.
// (R7) A receive counter of zero stops all receive channel transfers.
// (R8) A nonzero receive counter moves received words to memory while receive-full is set.
// (R9) Software loads the transmit pointer with the transmit buffer address first.
// (R10) A transmit counter of zero stops all transmit channel transfers.
// (R11) A nonzero transmit counter fetches words into transmit data while transmit-empty is set.
// (R12) Overrun sets on a second receive load without a read; status read clears it.
// (R13) Receive-end and transmit-end flags follow the channels' end-of-transfer signals.
// (R14) Transmit-empty is zero at reset or when disabled; the enable command sets it.
// (R15) Interrupt output is high while any flag and its mask bit are both one.
// (R16) Each transfer steps the pointer one word and decrements the counter; zero means end.
package smd_pkg;

   localparam int          ADDR_W     = 8;
   localparam int          NSRC       = 6;
   localparam int          CNT_W      = 16;

   // Byte addresses of the registers
   localparam logic [7:0]  OFF_CTRL   = 8'h00;
   localparam logic [7:0]  OFF_STATUS = 8'h04;
   localparam logic [7:0]  OFF_RXDATA = 8'h08;
   localparam logic [7:0]  OFF_TXDATA = 8'h0C;
   localparam logic [7:0]  OFF_IER    = 8'h10;
   localparam logic [7:0]  OFF_IDR    = 8'h14;
   localparam logic [7:0]  OFF_IMR    = 8'h18;
   localparam logic [7:0]  OFF_FCLR   = 8'h1C;
   localparam logic [7:0]  OFF_RX_BUFFER_ADDRESS  = 8'h20;
   localparam logic [7:0]  OFF_RXCNT  = 8'h24;
   localparam logic [7:0]  OFF_TX_BUFFER_ADDRESS  = 8'h28;
   localparam logic [7:0]  OFF_TXCNT  = 8'h2C;

   // Source bit positions in status, enable, disable and mask, then the enable bit B_ENS in status only
   localparam int          B_RXF      = 0;
   localparam int          B_TXE      = 1;
   localparam int          B_MODE_FAULT_FLAG     = 2;
   localparam int          B_OVR      = 3;
   localparam int          B_RXEND    = 4;
   localparam int          B_TXEND    = 5;
   localparam int          B_ENS      = 16;

   // Control command bits
   localparam int          B_CMD_EN   = 0;
   localparam int          B_CMD_DIS  = 1;

   // Reset values and channel step
   localparam logic [31:0] RST_WORD   = 32'h0000_0000;
   localparam logic [5:0]  RST_SRC    = 6'h00;
   localparam logic [15:0] RST_CNT    = 16'h0000;
   localparam logic [31:0] PTR_STEP   = 32'h0000_0004;

   typedef enum logic [0:0] {
      CH_IDLE = 1'b0,
      CH_BUSY = 1'b1
   } smd_ch_state_t;

   // Source field of a written word
   function automatic logic [NSRC-1:0] smd_src(input logic [31:0] w);
      return w[NSRC-1:0];
   endfunction

endpackage

// ### verilog/smd_chan_if.sv
// Link between the register bank and one transfer channel.
interface smd_chan_if;
   logic        wr_ptr;
   logic        wr_cnt;
   logic [31:0] wdata;
   logic        trig;
   logic [31:0] ptr;
   logic [15:0] cnt;
   logic        done;
   logic        chan_end;

   modport chan (input wr_ptr, wr_cnt, wdata, trig, output ptr, cnt, done, chan_end);
   modport ctl  (output wr_ptr, wr_cnt, wdata, trig, input ptr, cnt, done, chan_end);
endinterface

// ### verilog/smd_chan.sv
// One memory transfer channel: buffer pointer, buffer counter and request sequencing.
module smd_chan (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Register bank side
   smd_chan_if.chan         cif,
   // Memory side
   output logic             mem_req,
   output logic [31:0]      mem_addr,
   input  wire logic        mem_ack
);

   smd_pkg::smd_ch_state_t state_r;
   logic [31:0]            ptr_r;
   logic [15:0]            cnt_r;

   assign mem_req      = (state_r == smd_pkg::CH_BUSY);
   assign mem_addr     = ptr_r;
   assign cif.done     = mem_req & mem_ack;
   assign cif.ptr      = ptr_r;
   assign cif.cnt      = cnt_r;
   assign cif.chan_end = (cnt_r == smd_pkg::RST_CNT); // R16

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= smd_pkg::CH_IDLE;
      end else begin
         case (state_r)
            smd_pkg::CH_IDLE: begin
               if (cif.trig && (cnt_r != smd_pkg::RST_CNT)) begin // R7 R8 R10 R11
                  state_r <= smd_pkg::CH_BUSY;
               end
            end
            smd_pkg::CH_BUSY: begin
               if (mem_ack) begin
                  state_r <= smd_pkg::CH_IDLE;
               end
            end
            default: state_r <= smd_pkg::CH_IDLE;
         endcase
      end
   end

   // Software write wins over a completing transfer in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_r <= smd_pkg::RST_WORD;
      end else if (cif.wr_ptr) begin
         ptr_r <= cif.wdata;
      end else if (cif.done) begin
         ptr_r <= ptr_r + smd_pkg::PTR_STEP; // R16
      end
   end

   // Guard keeps a counter cleared mid-transfer from wrapping
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= smd_pkg::RST_CNT;
      end else if (cif.wr_cnt) begin
         cnt_r <= cif.wdata[15:0];
      end else if (cif.done && (cnt_r != smd_pkg::RST_CNT)) begin
         cnt_r <= cnt_r - 16'h0001; // R16
      end
   end

endmodule

// ### verilog/smd_irq.sv
// Interrupt mask with set-only and clear-only writes, and the interrupt output.
module smd_irq (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Mask writes
   input  wire logic        set_we,
   input  wire logic        clr_we,
   input  wire logic [5:0]  wsrc,
   // Sources and result
   input  wire logic [5:0]  flags,
   output logic [5:0]       mask,
   output logic             irq
);

   logic [5:0] mask_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= smd_pkg::RST_SRC;
      end else if (set_we) begin
         mask_r <= mask_r | wsrc; // R1 R2
      end else if (clr_we) begin
         mask_r <= mask_r & ~wsrc; // R1 R3
      end
   end

   assign mask = mask_r; // R4
   assign irq  = |(flags & mask_r); // R15

endmodule

// ### verilog/smd_regs.sv
// Register bank top: APB slave, status flags, data registers and two transfer channels.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
module smd_regs (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Serializer side
   input  wire logic        ser_rx_load,
   input  wire logic [31:0] ser_rx_word,
   input  wire logic        ser_tx_take,
   input  wire logic        ser_mode_fault,
   output logic [31:0]      tx_word,
   output logic             tx_word_valid,
   output logic             spi_enabled,
   // Receive channel memory port
   output logic             rxm_req,
   output logic [31:0]      rxm_addr,
   output logic [31:0]      rxm_wdata,
   input  wire logic        rxm_ack,
   // Transmit channel memory port
   output logic             txm_req,
   output logic [31:0]      txm_addr,
   input  wire logic [31:0] txm_rdata,
   input  wire logic        txm_ack,
   // Interrupt
   output logic             irq
);

   smd_chan_if rx_if ();
   smd_chan_if tx_if ();

   logic        en_r;
   logic        rxf_r;
   logic        txe_r;
   logic        mode_fault_flag_r;
   logic        ovr_r;
   logic [31:0] rx_data_r;
   logic [31:0] tx_data_r;
   logic [31:0] prdata_r;
   logic [5:0]  flags;
   logic [5:0]  mask;
   logic [31:0] rd_nxt;
   logic        rd_hit;

   // Access and setup phase strobes; side effects happen only in the access phase
   logic        acc;
   logic        wr;
   logic        rd;
   logic        setup_rd;

   assign acc      = psel & penable;
   assign wr       = acc & pwrite;
   assign rd       = acc & ~pwrite;
   assign setup_rd = psel & ~penable & ~pwrite;

   logic        wr_ctrl;
   logic        wr_txd;
   logic        wr_ier;
   logic        wr_idr;
   logic        wr_fclr;
   logic        rd_stat;
   logic        rd_rxd;

   assign wr_ctrl = wr & (paddr == smd_pkg::OFF_CTRL);
   assign wr_txd  = wr & (paddr == smd_pkg::OFF_TXDATA);
   assign wr_ier  = wr & (paddr == smd_pkg::OFF_IER);
   assign wr_idr  = wr & (paddr == smd_pkg::OFF_IDR);
   assign wr_fclr = wr & (paddr == smd_pkg::OFF_FCLR);
   assign rd_stat = rd & (paddr == smd_pkg::OFF_STATUS);
   assign rd_rxd  = rd & (paddr == smd_pkg::OFF_RXDATA);

   // Channel register writes
   assign rx_if.wr_ptr = wr & (paddr == smd_pkg::OFF_RX_BUFFER_ADDRESS); // R5
   assign rx_if.wr_cnt = wr & (paddr == smd_pkg::OFF_RXCNT); // R6
   assign rx_if.wdata  = pwdata;
   assign tx_if.wr_ptr = wr & (paddr == smd_pkg::OFF_TX_BUFFER_ADDRESS); // R9
   assign tx_if.wr_cnt = wr & (paddr == smd_pkg::OFF_TXCNT); // R6
   assign tx_if.wdata  = pwdata;

   // Channel triggers follow the data register flags
   assign rx_if.trig = rxf_r; // R8
   assign tx_if.trig = txe_r & en_r; // R11

   smd_chan u_rx_chan (
      .pclk     (pclk),
      .presetn  (presetn),
      .cif      (rx_if),
      .mem_req  (rxm_req),
      .mem_addr (rxm_addr),
      .mem_ack  (rxm_ack)
   );

   smd_chan u_tx_chan (
      .pclk     (pclk),
      .presetn  (presetn),
      .cif      (tx_if),
      .mem_req  (txm_req),
      .mem_addr (txm_addr),
      .mem_ack  (txm_ack)
   );

   // Enable state from the control command; disable wins if both bits are written
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_r <= 1'b0;
      end else if (wr_ctrl && pwdata[smd_pkg::B_CMD_DIS]) begin
         en_r <= 1'b0;
      end else if (wr_ctrl && pwdata[smd_pkg::B_CMD_EN]) begin
         en_r <= 1'b1;
      end
   end

   // Receive data register, loaded by the serializer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_data_r <= smd_pkg::RST_WORD;
      end else if (ser_rx_load) begin
         rx_data_r <= ser_rx_word;
      end
   end

   // Receive-full: a new load wins over a read in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxf_r <= 1'b0;
      end else if (ser_rx_load) begin
         rxf_r <= 1'b1;
      end else if (rd_rxd || rx_if.done) begin
         rxf_r <= 1'b0;
      end
   end

   // Overrun: second load before the first was taken; set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovr_r <= 1'b0;
      end else if (ser_rx_load && rxf_r && !(rd_rxd || rx_if.done)) begin
         ovr_r <= 1'b1; // R12
      end else if (rd_stat || (wr_fclr && pwdata[smd_pkg::B_OVR])) begin
         ovr_r <= 1'b0; // R12
      end
   end

   // Mode fault is sticky until status read or explicit clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_fault_flag_r <= 1'b0;
      end else if (ser_mode_fault) begin
         mode_fault_flag_r <= 1'b1;
      end else if (rd_stat || (wr_fclr && pwdata[smd_pkg::B_MODE_FAULT_FLAG])) begin
         mode_fault_flag_r <= 1'b0;
      end
   end

   // Transmit data register, written by software or by the transmit channel
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_data_r <= smd_pkg::RST_WORD;
      end else if (tx_if.done) begin
         tx_data_r <= txm_rdata; // R11
      end else if (wr_txd) begin
         tx_data_r <= pwdata;
      end
   end

   // Transmit-empty: zero while disabled, set by enable and by the serializer taking data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txe_r <= 1'b0; // R14
      end else if (wr_ctrl && pwdata[smd_pkg::B_CMD_DIS]) begin
         txe_r <= 1'b0; // R14
      end else if (wr_ctrl && pwdata[smd_pkg::B_CMD_EN]) begin
         txe_r <= 1'b1; // R14
      end else if (!en_r) begin
         txe_r <= 1'b0; // R14
      end else if (ser_tx_take && !txe_r) begin
         txe_r <= 1'b1;
      end else if (wr_txd || tx_if.done) begin
         txe_r <= 1'b0;
      end
   end

   assign tx_word       = tx_data_r;
   assign tx_word_valid = en_r & ~txe_r;
   assign spi_enabled   = en_r;
   assign rxm_wdata     = rx_data_r; // R8

   // Status flags in the shared source layout
   always_comb begin
      flags                   = smd_pkg::RST_SRC;
      flags[smd_pkg::B_RXF]   = rxf_r;
      flags[smd_pkg::B_TXE]   = txe_r;
      flags[smd_pkg::B_MODE_FAULT_FLAG]  = mode_fault_flag_r;
      flags[smd_pkg::B_OVR]   = ovr_r;
      flags[smd_pkg::B_RXEND] = rx_if.chan_end; // R13
      flags[smd_pkg::B_TXEND] = tx_if.chan_end; // R13
   end

   smd_irq u_irq (
      .pclk    (pclk),
      .presetn (presetn),
      .set_we  (wr_ier),
      .clr_we  (wr_idr),
      .wsrc    (smd_pkg::smd_src(pwdata)),
      .flags   (flags),
      .mask    (mask),
      .irq     (irq)
   );

   // Read decode; write-only registers read as zero without error
   always_comb begin
      rd_nxt = smd_pkg::RST_WORD;
      rd_hit = 1'b1;
      case (paddr)
         smd_pkg::OFF_CTRL,
         smd_pkg::OFF_TXDATA,
         smd_pkg::OFF_IER,
         smd_pkg::OFF_IDR,
         smd_pkg::OFF_FCLR: begin
            rd_nxt = smd_pkg::RST_WORD;
         end
         smd_pkg::OFF_STATUS: begin
            rd_nxt[5:0]            = flags;
            rd_nxt[smd_pkg::B_ENS] = en_r;
         end
         smd_pkg::OFF_RXDATA: begin
            rd_nxt = rx_data_r;
         end
         smd_pkg::OFF_IMR: begin
            rd_nxt[5:0] = mask; // R4
         end
         smd_pkg::OFF_RX_BUFFER_ADDRESS: begin
            rd_nxt = rx_if.ptr;
         end
         smd_pkg::OFF_RXCNT: begin
            rd_nxt[15:0] = rx_if.cnt; // R6
         end
         smd_pkg::OFF_TX_BUFFER_ADDRESS: begin
            rd_nxt = tx_if.ptr;
         end
         smd_pkg::OFF_TXCNT: begin
            rd_nxt[15:0] = tx_if.cnt; // R6
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   // Read data captured in the setup cycle so it comes from a flop at zero wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= smd_pkg::RST_WORD;
      end else if (setup_rd) begin
         prdata_r <= rd_nxt;
      end
   end

   assign prdata  = prdata_r;
   assign pready  = 1'b1;
   assign pslverr = acc & ~rd_hit;

endmodule

// ### bench/smd_mem_model.sv
// Memory stand-in for one transfer channel: answers after a set delay.
module smd_mem_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Channel side
   input  wire logic        req,
   input  wire logic [31:0] addr,
   input  wire logic [3:0]  lat,
   output logic             ack,
   output logic [31:0]      rdata
);
   logic [3:0] wait_r;

   // Count restarts for every request, so a slow answer never carries over
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         wait_r <= 4'h0;
      else if (!req || ack)
         wait_r <= 4'h0;
      else
         wait_r <= wait_r + 4'h1;
   end

   assign ack   = req && (wait_r == lat);
   // Outside an answer the data lines show the inverse, never a stale word
   assign rdata = ack ? (addr ^ 32'h5A5A_0000) : ~(addr ^ 32'h5A5A_0000);
endmodule

// ### bench/smd_regs_props.sv
// Port-level checks for the register bank and its two channels.
module smd_regs_props (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Bus
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pslverr,
   // Channels
   input wire logic        rxm_req,
   input wire logic [31:0] rxm_addr,
   input wire logic        rxm_ack,
   input wire logic        txm_req,
   input wire logic [31:0] txm_addr,
   input wire logic [31:0] txm_rdata,
   input wire logic        txm_ack,
   // Transmit data
   input wire logic [31:0] tx_word,
   input wire logic        tx_word_valid,
   input wire logic        spi_enabled
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_rx_req_hold: assert property (
      rxm_req && !rxm_ack |=> rxm_req && $stable(rxm_addr)) else $error("rx request moved");
   a_tx_req_hold: assert property (
      txm_req && !txm_ack |=> txm_req && $stable(txm_addr)) else $error("tx request moved");
   a_rx_ptr_step: assert property (
      rxm_req && rxm_ack |=> rxm_addr == $past(rxm_addr) + 32'h4) else $error("rx step");
   a_rx_idle_gap: assert property (
      rxm_req && rxm_ack |=> !rxm_req) else $error("rx no gap");
   a_tx_ptr_step: assert property (
      txm_req && txm_ack |=> !txm_req ##0 txm_addr == $past(txm_addr) + 32'h4)
      else $error("tx step");
   a_tx_word_load: assert property (
      txm_req && txm_ack |=> tx_word == $past(txm_rdata) && tx_word_valid)
      else $error("tx word not loaded");
   a_slverr_phase: assert property (
      pslverr |-> psel && penable) else $error("error outside access");
   a_tx_valid_en: assert property (
      tx_word_valid |-> spi_enabled) else $error("tx valid while disabled");
endmodule

bind smd_regs smd_regs_props smd_regs_props_i (.pclk, .presetn, .psel, .penable, .pslverr,
   .rxm_req, .rxm_addr, .rxm_ack, .txm_req, .txm_addr, .txm_rdata, .txm_ack, .tx_word,
   .tx_word_valid, .spi_enabled);

// ### bench/tb.sv
// Self-checking bench for the serial port mask and channel register bank.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_r;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd_r, ser_rx_word, tx_word, rxm_addr, rxm_wdata;
   logic [31:0] txm_addr, txm_rdata;
   logic        ser_rx_load, ser_tx_take, ser_mode_fault, tx_word_valid, spi_enabled;
   logic        rxm_req, rxm_ack, txm_req, txm_ack, irq;
   int          errors, n_checks;
   logic [7:0]  ta [6] = '{smd_pkg::OFF_IER, smd_pkg::OFF_IER, smd_pkg::OFF_IDR,
                           smd_pkg::OFF_IER, smd_pkg::OFF_IDR, smd_pkg::OFF_IDR};
   logic [31:0] td [6] = '{32'h5, 32'h2, 32'h4, 32'hFFFF_FFFF, 32'hFFFF_FFC2, 32'hFFFF_FFFF};
   logic [31:0] te [6] = '{32'h5, 32'h7, 32'h3, 32'h3F, 32'h3D, 32'h0};

   smd_regs smd_regs_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .ser_rx_load, .ser_rx_word, .ser_tx_take, .ser_mode_fault, .tx_word,
      .tx_word_valid, .spi_enabled, .rxm_req, .rxm_addr, .rxm_wdata, .rxm_ack, .txm_req,
      .txm_addr, .txm_rdata, .txm_ack, .irq);
   // Receive side answers slowly, transmit side at once
   smd_mem_model rx_mem (.clk(pclk), .rst_n(presetn), .req(rxm_req), .addr(rxm_addr),
      .lat(4'h3), .ack(rxm_ack), .rdata());
   smd_mem_model tx_mem (.clk(pclk), .rst_n(presetn), .req(txm_req), .addr(txm_addr),
      .lat(4'h0), .ack(txm_ack), .rdata(txm_rdata));

   initial pclk = 1'b0;
   always #20 pclk = ~pclk;

   task results();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task apb(input bit w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (n == 64) begin
         errors++;
         results();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd_r, err_r);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0, rd_r, err_r);
      chk(nm, e, rd_r);
   endtask

   task pulse_rx(input logic [31:0] w);
      ser_rx_load <= 1'b1;
      ser_rx_word <= w;
      @(posedge pclk);
      ser_rx_load <= 1'b0;
      @(posedge pclk);
   endtask

   task quiet(input bit tx);
      // Sampled at the falling edge, away from the edge that launches a request
      repeat (8) begin
         @(negedge pclk);
         chk("no_request", 0, tx ? txm_req : rxm_req);
      end
   endtask

   task wait_req(input bit tx, input bit lv);
      int n;
      n = 0;
      @(negedge pclk);
      while ((tx ? txm_req : rxm_req) !== lv && n < 64) begin
         @(negedge pclk);
         n++;
      end
      if (n == 64) begin
         errors++;
         results();
      end
   endtask

   task xfer(input bit tx, input logic [31:0] a, input logic [31:0] d);
      wait_req(tx, 1'b1);
      chk("req_addr", a, tx ? txm_addr : rxm_addr);
      if (!tx)
         chk("rx_wdata", d, rxm_wdata);
      wait_req(tx, 1'b0);
      @(posedge pclk);
      if (tx)
         chk("tx_word", d, {tx_word[31:1], tx_word[0] & tx_word_valid});
   endtask

   initial begin
      {presetn, psel, penable, pwrite, ser_rx_load, ser_tx_take, ser_mode_fault} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ser_rx_word = 32'h0;
      errors = 0;
      n_checks = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("irq", 0, irq);
      rd(smd_pkg::OFF_IMR, 32'h0, "mask");
      rd(smd_pkg::OFF_STATUS, 32'h30, "status");
      for (int i = 0; i < 6; i++) begin
         wr(ta[i], td[i]);
         rd(smd_pkg::OFF_IMR, te[i], "mask");
      end
      wr(smd_pkg::OFF_IER, 32'h10);
      chk("irq", 1, irq);
      wr(smd_pkg::OFF_IDR, 32'h10);
      chk("irq", 0, irq);
      apb(1'b0, 8'hFC, 32'h0, rd_r, err_r);
      chk("slverr", 1, err_r);
      chk("unmapped", 0, rd_r);
      rd(smd_pkg::OFF_IER, 32'h0, "wo_read");
      pulse_rx(32'h0000_00A1);
      pulse_rx(32'h0000_00B2);
      ser_mode_fault <= 1'b1;
      @(posedge pclk);
      ser_mode_fault <= 1'b0;
      quiet(1'b0);
      rd(smd_pkg::OFF_STATUS, 32'h3D, "status");
      rd(smd_pkg::OFF_STATUS, 32'h31, "status");
      wr(smd_pkg::OFF_RX_BUFFER_ADDRESS, 32'h1000);
      wr(smd_pkg::OFF_RXCNT, 32'h2);
      xfer(1'b0, 32'h1000, 32'hB2);
      pulse_rx(32'h0000_00C3);
      xfer(1'b0, 32'h1004, 32'hC3);
      rd(smd_pkg::OFF_RXCNT, 32'h0, "rx_count");
      rd(smd_pkg::OFF_RX_BUFFER_ADDRESS, 32'h1008, "rx_ptr");
      rd(smd_pkg::OFF_STATUS, 32'h30, "status");
      wr(smd_pkg::OFF_CTRL, 32'h1);
      rd(smd_pkg::OFF_STATUS, 32'h0001_0032, "status");
      quiet(1'b1);
      wr(smd_pkg::OFF_IER, 32'h2);
      chk("irq", 1, irq);
      wr(smd_pkg::OFF_IDR, 32'h3F);
      chk("irq", 0, irq);
      wr(smd_pkg::OFF_TX_BUFFER_ADDRESS, 32'h2000);
      wr(smd_pkg::OFF_TXCNT, 32'h1);
      xfer(1'b1, 32'h2000, 32'h5A5A_2000);
      rd(smd_pkg::OFF_TXCNT, 32'h0, "tx_count");
      rd(smd_pkg::OFF_TX_BUFFER_ADDRESS, 32'h2004, "tx_ptr");
      rd(smd_pkg::OFF_STATUS, 32'h0001_0030, "status");
      ser_tx_take <= 1'b1;
      @(posedge pclk);
      ser_tx_take <= 1'b0;
      quiet(1'b1);
      rd(smd_pkg::OFF_STATUS, 32'h0001_0032, "status");
      wr(smd_pkg::OFF_CTRL, 32'h2);
      rd(smd_pkg::OFF_STATUS, 32'h30, "status");
      chk("tx_valid", 0, tx_word_valid);
      results();
   end
endmodule
